// [core/utsc_shifter.sv]
// Bit shifter that sends one character frame or one sync break frame.
`timescale 1ns/10ps
`default_nettype none
module utsc_shifter (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Frame request
   input wire logic abort,
   input wire logic load,
   input wire utsc_pkg::utsc_frame_type frame,
   // Line and status
   output logic line,
   output logic busy,
   output logic done
);
   import utsc_pkg::*;

   typedef enum logic {ST_IDLE = 1'b0, ST_SHIFT = 1'b1} utsc_state_type;

   utsc_state_type state_reg;
   logic [13:0] shift_reg;
   logic [3:0] count_reg;
   logic [9:0] baud_reg;
   logic done_reg;

   assign line = shift_reg[0];
   assign busy = (state_reg == ST_SHIFT);
   assign done = done_reg;

   // Shift LSB first; ones fill from the top so the line rests high when idle.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         shift_reg <= 14'h3fff;
         count_reg <= 4'h0;
         baud_reg <= 10'h000;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (abort) begin
            state_reg <= ST_IDLE;
            shift_reg <= 14'h3fff;
            count_reg <= 4'h0;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  if (load) begin
                     if (frame.brk) begin
                        shift_reg <= 14'h2000;
                        count_reg <= 4'(BREAK_BITS);
                     end else begin
                        shift_reg <= {5'h1f, frame.data, 1'b0};
                        count_reg <= 4'(FRAME_BITS);
                     end
                     baud_reg <= 10'h000;
                     state_reg <= ST_SHIFT;
                  end
               end
               ST_SHIFT: begin
                  if (baud_reg == 10'(BIT_CYCLES - 1)) begin
                     baud_reg <= 10'h000;
                     shift_reg <= {1'b1, shift_reg[13:1]};
                     count_reg <= count_reg - 4'h1;
                     if (count_reg == 4'h1) begin
                        state_reg <= ST_IDLE;
                        done_reg <= 1'b1;
                     end
                  end else begin
                     baud_reg <= baud_reg + 10'h001;
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// [core/utsc_top.sv]
// Transmit status and control block of an asynchronous serial port.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
module utsc_top (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   // Transmit pin and encoded output
   output logic serial_tx_pin_out,
   output logic serial_tx_pin_oe,
   output logic ir_tx_out,
   // Interrupt
   output logic irq
);
   import utsc_pkg::*;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic [1:0] tx_irq_select_reg;
   logic tx_idle_polarity_invert_reg;
   logic send_break_request_reg;
   logic tx_enable_bit_reg;
   logic break_inflight_reg;
   logic [7:0] fifo_mem [FIFO_DEPTH];
   logic [1:0] wr_ptr_reg;
   logic [1:0] rd_ptr_reg;
   logic [2:0] count_reg;
   logic [1:0] irq_status_reg;
   logic [1:0] irq_mask_reg;
   logic [15:0] rdata_reg;
   logic ir_reg;
   logic [1:0] irq_status_next;

   logic tx_buffer_full_flag;
   logic tx_shifter_empty_flag;
   logic push;
   logic load_data;
   logic load_break;
   logic load_any;
   logic shifter_line;
   logic shifter_busy;
   logic shifter_done;
   logic ev_tx;
   logic ev_break;
   logic [15:0] status_control_view;
   utsc_frame_type frame;

   // ----------------------------------------------------------------------
   // Transfer decisions
   // ----------------------------------------------------------------------

   // full while every entry holds a character
   assign tx_buffer_full_flag = (count_reg == 3'(FIFO_DEPTH));
   // a write to a full buffer is dropped rather than overwriting the oldest character.
   assign push = wr && (addr == ADDR_TX_DATA) && tx_enable_bit_reg && !tx_buffer_full_flag;
   // a pending break goes ahead of buffered data.
   assign load_break = tx_enable_bit_reg && !shifter_busy && send_break_request_reg
                       && !break_inflight_reg;
   assign load_data = tx_enable_bit_reg && !shifter_busy && !send_break_request_reg
                      && (count_reg != 3'h0);
   assign load_any = load_break || load_data;
   // the load cycle counts as busy so the flag never blinks high between frames.
   assign tx_shifter_empty_flag = !shifter_busy && (count_reg == 3'h0) && !load_any;
   // One driver for the whole frame word keeps the struct from having split drivers.
   assign frame = {load_break, fifo_mem[rd_ptr_reg]};

   utsc_shifter u_shifter (
      .clk(clk),
      .reset(reset),
      .abort(!tx_enable_bit_reg),
      .load(load_any),
      .frame(frame),
      .line(shifter_line),
      .busy(shifter_busy),
      .done(shifter_done)
   );

   // ----------------------------------------------------------------------
   // Transmit buffer
   // ----------------------------------------------------------------------

   // Buffer storage holds no reset; the pointers and fill level decide what is valid.
   always_ff @(posedge clk) begin
      if (push) begin
         fifo_mem[wr_ptr_reg] <= wdata[7:0];
      end
   end

   // Pointers and fill level; flushes them whenever transmit is disabled.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ptr_reg <= 2'h0;
         rd_ptr_reg <= 2'h0;
         count_reg <= 3'h0;
      end else if (!tx_enable_bit_reg) begin
         wr_ptr_reg <= 2'h0;
         rd_ptr_reg <= 2'h0;
         count_reg <= 3'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 2'h1;
         end
         if (load_data) begin
            rd_ptr_reg <= rd_ptr_reg + 2'h1;
         end
         count_reg <= count_reg + 3'(push) - 3'(load_data);
      end
   end

   // ----------------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------------

   // Software fields; hardware clears the break request when its frame ends.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_irq_select_reg <= TXISEL_RESET;
         tx_idle_polarity_invert_reg <= 1'b0;
         tx_enable_bit_reg <= 1'b0;
         send_break_request_reg <= 1'b0;
      end else begin
         if (wr && (addr == ADDR_STATUS_CONTROL)) begin
            tx_irq_select_reg <= {wdata[BIT_TXISEL_HI], wdata[BIT_TXISEL_LO]};
            tx_idle_polarity_invert_reg <= wdata[BIT_INVERT];
            tx_enable_bit_reg <= wdata[BIT_ENABLE];
         end
         if (shifter_done && break_inflight_reg) begin
            send_break_request_reg <= 1'b0;
         end else if (wr && (addr == ADDR_STATUS_CONTROL) && wdata[BIT_BREAK]) begin
            send_break_request_reg <= 1'b1;
         end
      end
   end

   // Marks that the frame in the shifter is a break, so its end can clear the request.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         break_inflight_reg <= 1'b0;
      end else if (load_break) begin
         break_inflight_reg <= 1'b1;
      end else if (shifter_done || !tx_enable_bit_reg) begin
         break_inflight_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt events
   // ----------------------------------------------------------------------

   // last character out; per-transfer modes, reserved code raises nothing.
   always_comb begin
      case (utsc_txisel_type'(tx_irq_select_reg))
         TXI_EACH: ev_tx = load_data;
         TXI_DONE: ev_tx = shifter_done && (count_reg == 3'h0);
         TXI_EMPTY: ev_tx = load_data && (count_reg == 3'h1) && !push;
         TXI_RSVD: ev_tx = 1'b0;
         default: ev_tx = 1'b0;
      endcase
   end
   assign ev_break = shifter_done && break_inflight_reg;

   // Sticky bits: a new event in the clearing cycle survives the write of one.
   always_comb begin
      irq_status_next = irq_status_reg;
      if (wr && (addr == ADDR_IRQ_STATUS)) begin
         irq_status_next = irq_status_reg & ~wdata[1:0];
      end
      irq_status_next[IRQ_TX] = irq_status_next[IRQ_TX] | ev_tx;
      irq_status_next[IRQ_BREAK] = irq_status_next[IRQ_BREAK] | ev_break;
   end

   // Status and mask registers.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq_status_reg <= IRQ_RESET;
         irq_mask_reg <= IRQ_RESET;
      end else begin
         irq_status_reg <= irq_status_next;
         if (wr && (addr == ADDR_IRQ_MASK)) begin
            irq_mask_reg <= wdata[1:0];
         end
      end
   end

   assign irq = |(irq_status_reg & irq_mask_reg);

   // ----------------------------------------------------------------------
   // Read path and pins
   // ----------------------------------------------------------------------

   // Bit 12 and the receive half stay zero.
   always_comb begin
      status_control_view = 16'h0000;
      status_control_view[BIT_TXISEL_HI] = tx_irq_select_reg[1];
      status_control_view[BIT_INVERT] = tx_idle_polarity_invert_reg;
      status_control_view[BIT_TXISEL_LO] = tx_irq_select_reg[0];
      status_control_view[BIT_BREAK] = send_break_request_reg;
      status_control_view[BIT_ENABLE] = tx_enable_bit_reg;
      status_control_view[BIT_FULL] = tx_buffer_full_flag;
      status_control_view[BIT_EMPTY] = tx_shifter_empty_flag;
   end

   // Read data stand only in the cycle after the strobe; the data register reads zero.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_reg <= 16'h0000;
      end else if (rd) begin
         case (addr)
            ADDR_STATUS_CONTROL: rdata_reg <= status_control_view;
            ADDR_IRQ_STATUS: rdata_reg <= {14'h0000, irq_status_reg};
            ADDR_IRQ_MASK: rdata_reg <= {14'h0000, irq_mask_reg};
            default: rdata_reg <= 16'h0000;
         endcase
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   // encoded output rests at the level the invert bit picks.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ir_reg <= 1'b0;
      end else begin
         ir_reg <= tx_idle_polarity_invert_reg ? shifter_line : !shifter_line;
      end
   end

   assign rdata = rdata_reg;
   assign serial_tx_pin_oe = tx_enable_bit_reg;
   assign serial_tx_pin_out = shifter_line;
   assign ir_tx_out = ir_reg;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------

   done_irq_a: assert property (
      @(posedge clk) disable iff (reset)
      (tx_irq_select_reg == 2'b01 && shifter_done && count_reg == 3'h0)
      |=> irq_status_reg[IRQ_TX] && tx_shifter_empty_flag)
      else $error("Last character out did not raise the transmit event.");

   empty_irq_a: assert property (
      @(posedge clk) disable iff (reset)
      (tx_irq_select_reg == 2'b10 && load_data && count_reg == 3'h1 && !push)
      |=> irq_status_reg[IRQ_TX] && count_reg == 3'h0 && shifter_busy)
      else $error("Emptying transfer did not raise the transmit event.");

   idle_polarity_a: assert property (
      @(posedge clk) disable iff (reset)
      (!shifter_busy && shifter_line) |=> ir_tx_out == $past(tx_idle_polarity_invert_reg))
      else $error("Encoded output idle level does not follow the invert bit.");

   break_clear_a: assert property (
      @(posedge clk) disable iff (reset)
      (shifter_done && break_inflight_reg) |=> !send_break_request_reg)
      else $error("Break request not cleared after the break frame.");

   disable_flush_a: assert property (
      @(posedge clk) disable iff (reset)
      !tx_enable_bit_reg |=> count_reg == 3'h0 && !shifter_busy)
      else $error("Disabled transmitter kept buffered data or a frame.");

   full_flag_a: assert property (
      @(posedge clk) disable iff (reset)
      (rd && addr == ADDR_STATUS_CONTROL) |=> rdata[BIT_FULL] == $past(count_reg == 3'h4))
      else $error("Buffer full flag disagrees with the fill level.");

   empty_flag_a: assert property (
      @(posedge clk) disable iff (reset)
      (rd && addr == ADDR_STATUS_CONTROL)
      |=> rdata[BIT_EMPTY] == ($past(count_reg) == 3'h0 && !$past(shifter_busy)
                                && !$past(load_any)))
      else $error("Shifter empty flag disagrees with shifter and buffer.");

endmodule
`default_nettype wire

// [include/utsc_pkg.sv]
// Constants and types of the uart transmit status and control block.
`default_nettype none
package utsc_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned BIT_TIME_NS = 8680;
   localparam int unsigned BIT_CYCLES = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FRAME_BITS = 10;
   localparam int unsigned BREAK_BITS = 14;
   localparam int unsigned FIFO_DEPTH = 4;

   // ----------------------------------------------------------------------
   // Register map and field positions
   // ----------------------------------------------------------------------
   localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_TX_DATA = 2'h1;
   localparam logic [1:0] ADDR_IRQ_STATUS = 2'h2;
   localparam logic [1:0] ADDR_IRQ_MASK = 2'h3;
   localparam int unsigned BIT_TXISEL_HI = 15;
   localparam int unsigned BIT_INVERT = 14;
   localparam int unsigned BIT_TXISEL_LO = 13;
   localparam int unsigned BIT_BREAK = 11;
   localparam int unsigned BIT_ENABLE = 10;
   localparam int unsigned BIT_FULL = 9;
   localparam int unsigned BIT_EMPTY = 8;
   localparam int unsigned IRQ_TX = 0;
   localparam int unsigned IRQ_BREAK = 1;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   localparam logic [1:0] TXISEL_RESET = 2'h0;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      TXI_EACH = 2'b00,
      TXI_DONE = 2'b01,
      TXI_EMPTY = 2'b10,
      TXI_RSVD = 2'b11
   } utsc_txisel_type;

   typedef struct packed {
      logic brk;
      logic [7:0] data;
   } utsc_frame_type;

endpackage
`default_nettype wire

// [testbench/test_uart_transmit_status_control.sv]
// Self-checking testbench of the transmit status and control block.
`timescale 1ns/10ps
`default_nettype none
module test_uart_transmit_status_control;
   import utsc_pkg::*;

   // ----------------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------------
   localparam int FRAME = FRAME_BITS * BIT_CYCLES;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic tx_out;
   logic tx_oe;
   logic ir_out;
   logic irq;
   logic [15:0] rv;
   int mismatches = 0;
   int num_checks = 0;
   // The pin has a pull-up, so a released line reads high.
   wire logic line_w = tx_oe ? tx_out : 1'b1;

   utsc_top i_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .serial_tx_pin_out(tx_out), .serial_tx_pin_oe(tx_oe),
      .ir_tx_out(ir_out), .irq(irq));
   utsc_remote_rx #(.BIT_CYC(BIT_CYCLES)) i_rx (.clk(clk), .line(line_w));

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("Comparisons %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // One-cycle strobes; the leading edge wait keeps two calls from colliding.
   task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   // Control word: select high, invert, select low, break, enable.
   task automatic ctrl(input logic [1:0] sel, input logic inv, input logic brk, input logic en);
      wr_reg(ADDR_STATUS_CONTROL, {sel[1], inv, sel[0], 1'b0, brk, en, 10'h000});
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // Bounded wait for n received bytes, or for the interrupt when n is zero.
   task automatic wait_for(input int n);
      int k;
      k = 0;
      while ((n == 0 ? irq !== 1'b1 : i_rx.rx_q.size() < n) && k < 40000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 40000) begin
         mismatches++;
         $display("BAD wait expected %0d seen %0d", n, i_rx.rx_q.size());
         finish_test();
      end
      @(negedge clk);
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   // reset view.
   task automatic t_reset();
      rd_reg(ADDR_STATUS_CONTROL, rv);
      check("status", rv, 16'h0100);
      rd_reg(ADDR_TX_DATA, rv);
      check("data read", rv, 16'h0000);
      check("pin enable", 16'(tx_oe), 16'h0000);
      check("encoded idle", 16'(ir_out), 16'h0000);
   endtask

   task automatic t_invert();
      wr_reg(ADDR_STATUS_CONTROL, 16'h5300);
      settle(3);
      check("encoded idle", 16'(ir_out), 16'h0001);
      rd_reg(ADDR_STATUS_CONTROL, rv);
      check("status", rv, 16'h4100);
      ctrl(2'b00, 1'b0, 1'b0, 1'b0);
      settle(3);
      check("encoded idle", 16'(ir_out), 16'h0000);
   endtask

   task automatic t_fill();
      wr_reg(ADDR_IRQ_MASK, 16'h0000);
      ctrl(2'b00, 1'b0, 1'b0, 1'b1);
      wr_reg(ADDR_IRQ_STATUS, 16'h0003);
      check("pin enable", 16'(tx_oe), 16'h0001);
      for (int i = 0; i < 6; i++) begin
         wr_reg(ADDR_TX_DATA, 16'h0030 + 16'(i));
      end
      rd_reg(ADDR_STATUS_CONTROL, rv);
      check("status full", rv, 16'h0600);
      rd_reg(ADDR_IRQ_STATUS, rv);
      check("event", rv, 16'h0001);
      check("masked irq", 16'(irq), 16'h0000);
      wr_reg(ADDR_IRQ_MASK, 16'h0001);
      settle(1);
      check("irq", 16'(irq), 16'h0001);
      wr_reg(ADDR_IRQ_STATUS, 16'h0001);
      settle(1);
      check("cleared irq", 16'(irq), 16'h0000);
      wait_for(1);
      check("byte", 16'(i_rx.rx_q[0]), 16'h0030);
      settle(BIT_CYCLES);
      rd_reg(ADDR_STATUS_CONTROL, rv);
      check("status room", rv, 16'h0400);
      check("next load irq", 16'(irq), 16'h0001);
      ctrl(2'b00, 1'b0, 1'b0, 1'b0);
      settle(2);
      check("pin enable", 16'(tx_oe), 16'h0000);
      check("line idle", 16'(tx_out), 16'h0001);
      rd_reg(ADDR_STATUS_CONTROL, rv);
      check("flushed", rv, 16'h0100);
      settle(FRAME);
      i_rx.rx_q.delete();
   endtask

   task automatic t_done();
      ctrl(2'b01, 1'b0, 1'b0, 1'b1);
      wr_reg(ADDR_IRQ_STATUS, 16'h0003);
      wr_reg(ADDR_TX_DATA, 16'h00a5);
      settle(20);
      check("early irq", 16'(irq), 16'h0000);
      wait_for(0);
      check("byte", 16'(i_rx.rx_q[0]), 16'h00a5);
      rd_reg(ADDR_STATUS_CONTROL, rv);
      check("status", rv, 16'h2500);
      i_rx.rx_q.delete();
   endtask

   // event only when the buffer empties, and none for the reserved code.
   task automatic t_select();
      ctrl(2'b10, 1'b0, 1'b0, 1'b1);
      for (int i = 1; i < 4; i++) begin
         wr_reg(ADDR_TX_DATA, 16'h0011 * 16'(i));
      end
      wr_reg(ADDR_IRQ_STATUS, 16'h0003);
      wait_for(2);
      rd_reg(ADDR_IRQ_STATUS, rv);
      check("event", rv, 16'h0000);
      wait_for(3);
      rd_reg(ADDR_IRQ_STATUS, rv);
      check("event", rv, 16'h0001);
      check("byte", 16'(i_rx.rx_q[2]), 16'h0033);
      settle(BIT_CYCLES);
      ctrl(2'b11, 1'b0, 1'b0, 1'b1);
      wr_reg(ADDR_IRQ_STATUS, 16'h0003);
      wr_reg(ADDR_TX_DATA, 16'h005a);
      wait_for(4);
      settle(BIT_CYCLES);
      rd_reg(ADDR_IRQ_STATUS, rv);
      check("reserved event", rv, 16'h0000);
      rd_reg(ADDR_STATUS_CONTROL, rv);
      check("status", rv, 16'ha500);
   endtask

   // sync break and its hardware clear.
   task automatic t_break();
      int b0;
      b0 = i_rx.breaks;
      wr_reg(ADDR_IRQ_MASK, 16'h0002);
      ctrl(2'b01, 1'b0, 1'b0, 1'b1);
      wr_reg(ADDR_IRQ_STATUS, 16'h0003);
      ctrl(2'b01, 1'b0, 1'b1, 1'b1);
      wait_for(0);
      check("break low", 16'(i_rx.last_low), 16'(13 * BIT_CYCLES));
      check("breaks", 16'(i_rx.breaks - b0), 16'h0001);
      rd_reg(ADDR_STATUS_CONTROL, rv);
      check("status", rv, 16'h2500);
   endtask

   // ----------------------------------------------------------------------
   // Clock, reset and sequence
   // ----------------------------------------------------------------------
   initial begin
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_invert();
      t_fill();
      t_done();
      t_select();
      t_break();
      finish_test();
   end
endmodule
`default_nettype wire

// [testbench/utsc_remote_rx.sv]
// Remote serial receiver model that watches the transmit line.
`timescale 1ns/10ps
`default_nettype none
module utsc_remote_rx #(
   parameter int BIT_CYC = 868
) (
   // Clock and line
   input wire logic clk,
   input wire logic line
);
   logic [7:0] rx_q[$];
   logic [7:0] shift_reg;
   int breaks = 0;
   int low_run = 0;
   int last_low = 0;

   // Length of the latest low stretch, which tells a break from a character.
   always @(posedge clk) begin
      if (line === 1'b0) begin
         low_run <= low_run + 1;
      end else begin
         if (low_run != 0) begin
            last_low <= low_run;
         end
         low_run <= 0;
      end
   end

   // Sample mid-bit; a low stop bit is a break, so wait for idle before hunting again.
   initial begin
      forever begin
         @(negedge line);
         repeat (BIT_CYC / 2) @(posedge clk);
         if (line === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
               repeat (BIT_CYC) @(posedge clk);
               shift_reg[i] = line;
            end
            repeat (BIT_CYC) @(posedge clk);
            if (line === 1'b1) begin
               rx_q.push_back(shift_reg);
            end else begin
               breaks++;
               wait (line === 1'b1);
            end
         end
      end
   end
endmodule
`default_nettype wire
